// ---- verilog/scpi_parser_pkg.sv ----
// Constants, keyword tree table and codes for the command message parser
package scpi_parser_pkg;

   // Byte width and keyword buffer sizes
   localparam int BYTE_W = 8;
   localparam int KW_MAX = 12;                  // Longest keyword in letters
   localparam int KW_BITS = KW_MAX * BYTE_W;    // Packed keyword buffer width
   localparam int NODE_W = 5;

   // Characters the parser reacts to
   localparam logic [7:0] CH_LF = 8'h0a;        // Line feed terminator
   localparam logic [7:0] CH_CR = 8'h0d;        // Carriage return terminator
   localparam logic [7:0] CH_SPACE = 8'h20;     // Data separator
   localparam logic [7:0] CH_STAR = 8'h2a;      // Common command lead
   localparam logic [7:0] CH_COLON = 8'h3a;     // Keyword separator or root
   localparam logic [7:0] CH_SEMI = 8'h3b;      // Message unit separator
   localparam logic [7:0] CH_QUERY = 8'h3f;     // Query mark
   localparam logic [7:0] CH_UP_A = 8'h41;
   localparam logic [7:0] CH_UP_Z = 8'h5a;
   localparam logic [7:0] CH_LO_A = 8'h61;
   localparam logic [7:0] CH_LO_Z = 8'h7a;
   localparam logic [7:0] CASE_BIT = 8'h20;     // Lower minus upper case

   // Error codes kept for readout
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_UNDEF = 8'h01;    // Keyword not at this level
   localparam logic [7:0] ERR_SYNTAX = 8'h02;   // Character not allowed here
   localparam logic [7:0] ERR_LONG = 8'h03;     // Keyword longer than any known

   // Tree nodes; node 0 is the root
   localparam logic [4:0] N_ROOT = 5'h00;
   localparam logic [4:0] N_SOUR = 5'h04;       // Optional keyword
   localparam logic [4:0] NODE_LAST = 5'h17;

   // Parser states
   typedef enum logic [2:0] {
      S_UNIT = 3'b000,     // Start of message unit
      S_KEY = 3'b001,      // Collecting keyword letters
      S_QRY = 3'b010,      // After query mark
      S_DATA = 3'b011,     // Passing parameter bytes
      S_COMMON = 3'b100,   // Passing common command bytes
      S_DISCARD = 3'b101   // Dropping rest of a bad message
   } state_e;

   // Long spelling, right justified, first letter highest
   function automatic logic [KW_BITS-1:0] kw_text(input logic [4:0] n);
      case (n)
         5'h01: kw_text = "INITIATE";
         5'h02: kw_text = "MEASURE";
         5'h03: kw_text = "OUTPUT";
         5'h04: kw_text = "SOURCE";
         5'h05: kw_text = "STATUS";
         5'h06: kw_text = "SYSTEM";
         5'h07, 5'h15: kw_text = "VOLTAGE";
         5'h08, 5'h16: kw_text = "CURRENT";
         5'h09: kw_text = "FUNCTION";
         5'h0a: kw_text = "OPERATION";
         5'h0b: kw_text = "PRESET";
         5'h0c: kw_text = "QUESTIONABLE";
         5'h0d: kw_text = "CONDITION";
         5'h0e: kw_text = "ENABLE";
         5'h0f: kw_text = "EVENT";
         5'h10, 5'h17: kw_text = "LEVEL";
         5'h11: kw_text = "IMMEDIATE";
         5'h12: kw_text = "TRIGGERED";
         5'h13: kw_text = "STATE";
         5'h14: kw_text = "ERROR";
         default: kw_text = '0;
      endcase
   endfunction

   // Letters in the short spelling
   function automatic logic [3:0] kw_short_len(input logic [4:0] n);
      case (n)
         5'h10, 5'h11, 5'h14, 5'h17: kw_short_len = 4'h3;
         default: kw_short_len = 4'h4;
      endcase
   endfunction

   // Letters in the long spelling
   function automatic logic [3:0] kw_long_len(input logic [4:0] n);
      case (n)
         5'h02, 5'h07, 5'h08, 5'h15, 5'h16: kw_long_len = 4'h7;
         5'h01, 5'h09: kw_long_len = 4'h8;
         5'h03, 5'h04, 5'h05, 5'h06, 5'h0b, 5'h0e: kw_long_len = 4'h6;
         5'h0a, 5'h0d, 5'h11, 5'h12: kw_long_len = 4'h9;
         5'h0c: kw_long_len = 4'hc;
         default: kw_long_len = 4'h5;
      endcase
   endfunction

   // Level at which a node is resolved
   function automatic logic [4:0] kw_parent(input logic [4:0] n);
      case (n)
         5'h0a, 5'h0b, 5'h0c: kw_parent = 5'h05;
         5'h0d, 5'h0e, 5'h0f: kw_parent = 5'h0a;
         5'h10: kw_parent = 5'h07;
         5'h11, 5'h12: kw_parent = 5'h10;
         5'h13: kw_parent = 5'h03;
         5'h14: kw_parent = 5'h06;
         5'h15, 5'h16: kw_parent = 5'h02;
         5'h17: kw_parent = 5'h08;
         default: kw_parent = N_ROOT;
      endcase
   endfunction

endpackage : scpi_parser_pkg

// ---- verilog/scpi_message_parser.sv ----
// Parser that splits received program messages into keywords, units and data
// Function
// - Keywords match in short or long spelling
// - Letter case is ignored in keywords
// - Partial truncations are rejected with error
// - Colon between keywords descends one level
// - Question mark after last keyword marks query
// - Parameters follow keyword after one space
// - Semicolons delimit units, each processed until an error drops the rest
// - Leading colon returns to root level
// - Line feed or carriage return ends message
// - Line feed right after return is ignored
// - Terminator returns tree position to root
// - Optional keyword may be dropped, same result
// - Root holds the listed branches
// - After semicolon resolve as sibling of last
// - Unknown keyword at retained level is error
// - Asterisk unit is a common command
module scpi_message_parser (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Received byte stream
   input wire logic in_valid,
   input wire logic [7:0] in_byte,
   // Keyword resolved
   output logic kw_valid_q,
   output logic [4:0] kw_node_q,
   // Message unit finished
   output logic unit_valid_q,
   output logic [4:0] unit_node_q,
   output logic unit_query_q,
   output logic unit_common_q,
   // Parameter or common command bytes
   output logic data_valid_q,
   output logic [7:0] data_byte_q,
   // Message ended
   output logic msg_end_q,
   // Errors
   output logic err_valid_q,
   output logic [7:0] err_code_q,
   // Current tree level
   output logic [4:0] level_q
);

   // Fold a letter to upper case
   function automatic logic [7:0] to_upper(input logic [7:0] c);
      if (c >= scpi_parser_pkg::CH_LO_A && c <= scpi_parser_pkg::CH_LO_Z) begin
         to_upper = c - scpi_parser_pkg::CASE_BIT;
      end else begin
         to_upper = c;
      end
   endfunction

   // Short or exact long spelling only
   function automatic logic kw_match(input logic [4:0] n,
                                     input logic [scpi_parser_pkg::KW_BITS-1:0] b,
                                     input logic [3:0] len);
      logic [scpi_parser_pkg::KW_BITS-1:0] t;
      logic [3:0] ll;
      logic [3:0] sl;
      t = scpi_parser_pkg::kw_text(n);
      ll = scpi_parser_pkg::kw_long_len(n);
      sl = scpi_parser_pkg::kw_short_len(n);
      kw_match = (len == ll && b == t) ||
                 (len == sl && b == (t >> (scpi_parser_pkg::BYTE_W * (int'(ll) - int'(sl)))));
   endfunction

   // Search the children of one level
   function automatic logic [5:0] find_kw(input logic [scpi_parser_pkg::KW_BITS-1:0] b,
                                          input logic [3:0] len,
                                          input logic [4:0] lvl);
      logic [5:0] r;
      r = '0;
      for (int i = 1; i <= int'(scpi_parser_pkg::NODE_LAST); i++) begin
         if (scpi_parser_pkg::kw_parent(5'(i)) == lvl && kw_match(5'(i), b, len)) begin
            r = {1'b1, 5'(i)};
         end
      end
      find_kw = r;
   endfunction

   // Parser state
   scpi_parser_pkg::state_e state_q, state_d;
   logic [scpi_parser_pkg::KW_BITS-1:0] buf_q, buf_d;   // Folded keyword letters
   logic [3:0] len_q, len_d;                            // Letters held
   logic [4:0] last_level_q, last_level_d;              // Level of last keyword
   logic [4:0] node_q, node_d;                          // Last keyword of unit
   logic [4:0] level_d;
   logic query_q, query_d;
   logic common_q, common_d;
   logic last_cr_q, last_cr_d;                          // Previous byte was return
   // Output next values
   logic kw_valid_d, unit_valid_d, unit_query_d, unit_common_d;
   logic data_valid_d, msg_end_d, err_valid_d;
   logic [4:0] kw_node_d, unit_node_d;
   logic [7:0] data_byte_d, err_code_d;
   // Byte classes and lookup result
   logic [7:0] up;
   logic is_letter, is_term, skip, hit, err;
   logic [4:0] hit_node;
   logic [7:0] err_code;

   assign up = to_upper(in_byte);
   assign is_letter = up >= scpi_parser_pkg::CH_UP_A && up <= scpi_parser_pkg::CH_UP_Z;
   assign is_term = in_byte == scpi_parser_pkg::CH_LF ||
                    in_byte == scpi_parser_pkg::CH_CR;
   assign skip = in_byte == scpi_parser_pkg::CH_LF && last_cr_q;
   assign {hit, hit_node} = find_kw(buf_q, len_q, level_q);

   // Next state of the parser and its output pulses
   always_comb begin
      state_d = state_q;
      buf_d = buf_q;
      len_d = len_q;
      level_d = level_q;
      last_level_d = last_level_q;
      node_d = node_q;
      query_d = query_q;
      common_d = common_q;
      last_cr_d = last_cr_q;
      kw_valid_d = 1'b0;
      kw_node_d = kw_node_q;
      unit_valid_d = 1'b0;
      unit_node_d = unit_node_q;
      unit_query_d = unit_query_q;
      unit_common_d = unit_common_q;
      data_valid_d = 1'b0;
      data_byte_d = data_byte_q;
      msg_end_d = 1'b0;
      err_valid_d = 1'b0;
      err_code_d = err_code_q;
      err = 1'b0;
      err_code = scpi_parser_pkg::ERR_SYNTAX;
      if (in_valid) begin
         last_cr_d = in_byte == scpi_parser_pkg::CH_CR;
      end
      if (in_valid && !skip) begin
         // Keyword ends on a separator: report it and record position
         if (state_q == scpi_parser_pkg::S_KEY && !is_letter) begin
            if (hit) begin
               kw_valid_d = 1'b1;
               kw_node_d = hit_node;
               node_d = hit_node;
               last_level_d = level_q;
            end
         end
         case (state_q)
            scpi_parser_pkg::S_UNIT: begin
               query_d = 1'b0;
               common_d = 1'b0;
               buf_d = '0;
               len_d = 4'h0;
               if (is_term) begin
                  msg_end_d = 1'b1;
               end else if (in_byte == scpi_parser_pkg::CH_COLON) begin
                  level_d = scpi_parser_pkg::N_ROOT;
                  state_d = scpi_parser_pkg::S_KEY;
               end else if (in_byte == scpi_parser_pkg::CH_STAR) begin
                  common_d = 1'b1;
                  state_d = scpi_parser_pkg::S_COMMON;
               end else if (is_letter) begin
                  buf_d = {{(scpi_parser_pkg::KW_BITS-scpi_parser_pkg::BYTE_W){1'b0}}, up};
                  len_d = 4'h1;
                  state_d = scpi_parser_pkg::S_KEY;
               end else if (in_byte != scpi_parser_pkg::CH_SPACE) begin
                  err = 1'b1;
               end
            end
            scpi_parser_pkg::S_KEY: begin
               if (is_letter) begin
                  if (len_q == 4'(scpi_parser_pkg::KW_MAX)) begin
                     err = 1'b1;
                     err_code = scpi_parser_pkg::ERR_LONG;
                  end else begin
                     buf_d = {buf_q[scpi_parser_pkg::KW_BITS-scpi_parser_pkg::BYTE_W-1:0], up};
                     len_d = len_q + 4'h1;
                  end
               end else if (!hit) begin
                  err = 1'b1;
                  err_code = scpi_parser_pkg::ERR_UNDEF;
               end else if (in_byte == scpi_parser_pkg::CH_COLON) begin
                  // Optional keyword leaves the level where it was
                  level_d = (hit_node == scpi_parser_pkg::N_SOUR) ? level_q
                                                                  : hit_node;
                  buf_d = '0;
                  len_d = 4'h0;
               end else if (in_byte == scpi_parser_pkg::CH_QUERY) begin
                  query_d = 1'b1;
                  state_d = scpi_parser_pkg::S_QRY;
               end else if (in_byte == scpi_parser_pkg::CH_SPACE) begin
                  state_d = scpi_parser_pkg::S_DATA;
               end else if (!is_term && in_byte != scpi_parser_pkg::CH_SEMI) begin
                  err = 1'b1;
               end
            end
            scpi_parser_pkg::S_QRY: begin
               if (in_byte == scpi_parser_pkg::CH_SPACE) begin
                  state_d = scpi_parser_pkg::S_DATA;
               end else if (!is_term && in_byte != scpi_parser_pkg::CH_SEMI) begin
                  err = 1'b1;
               end
            end
            scpi_parser_pkg::S_DATA, scpi_parser_pkg::S_COMMON: begin
               if (!is_term && in_byte != scpi_parser_pkg::CH_SEMI) begin
                  data_valid_d = 1'b1;
                  data_byte_d = in_byte;
                  if (state_q == scpi_parser_pkg::S_COMMON &&
                      in_byte == scpi_parser_pkg::CH_QUERY) begin
                     query_d = 1'b1;
                  end
               end
            end
            scpi_parser_pkg::S_DISCARD: begin
               // Bytes are dropped until the terminator below
            end
            default: begin
               state_d = scpi_parser_pkg::S_DISCARD;
            end
         endcase
         // Unit or message closes on a separator or terminator
         if (!err && state_q != scpi_parser_pkg::S_UNIT &&
             state_q != scpi_parser_pkg::S_DISCARD &&
             (is_term || in_byte == scpi_parser_pkg::CH_SEMI)) begin
            unit_valid_d = 1'b1;
            unit_node_d = (state_q == scpi_parser_pkg::S_KEY) ? hit_node : node_q;
            unit_query_d = query_q;
            unit_common_d = common_q;
            state_d = scpi_parser_pkg::S_UNIT;
            level_d = (state_q == scpi_parser_pkg::S_KEY) ? level_q
                                                           : last_level_q;
         end
         // Error: keep code and drop the rest of the message
         if (err) begin
            err_valid_d = 1'b1;
            err_code_d = err_code;
            state_d = scpi_parser_pkg::S_DISCARD;
         end
         // Terminator: back to the root for the next message
         if (is_term && state_q != scpi_parser_pkg::S_UNIT) begin
            msg_end_d = 1'b1;
            state_d = scpi_parser_pkg::S_UNIT;
         end
         if (is_term) begin
            level_d = scpi_parser_pkg::N_ROOT;
            last_level_d = scpi_parser_pkg::N_ROOT;
         end
      end
   end

   // Register the parser state and outputs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= scpi_parser_pkg::S_UNIT;
         buf_q <= '0;
         len_q <= 4'h0;
         level_q <= scpi_parser_pkg::N_ROOT;
         last_level_q <= scpi_parser_pkg::N_ROOT;
         node_q <= scpi_parser_pkg::N_ROOT;
         query_q <= 1'b0;
         common_q <= 1'b0;
         last_cr_q <= 1'b0;
         kw_valid_q <= 1'b0;
         kw_node_q <= scpi_parser_pkg::N_ROOT;
         unit_valid_q <= 1'b0;
         unit_node_q <= scpi_parser_pkg::N_ROOT;
         unit_query_q <= 1'b0;
         unit_common_q <= 1'b0;
         data_valid_q <= 1'b0;
         data_byte_q <= 8'h00;
         msg_end_q <= 1'b0;
         err_valid_q <= 1'b0;
         err_code_q <= scpi_parser_pkg::ERR_NONE;
      end else begin
         state_q <= state_d;
         buf_q <= buf_d;
         len_q <= len_d;
         level_q <= level_d;
         last_level_q <= last_level_d;
         node_q <= node_d;
         query_q <= query_d;
         common_q <= common_d;
         last_cr_q <= last_cr_d;
         kw_valid_q <= kw_valid_d;
         kw_node_q <= kw_node_d;
         unit_valid_q <= unit_valid_d;
         unit_node_q <= unit_node_d;
         unit_query_q <= unit_query_d;
         unit_common_q <= unit_common_d;
         data_valid_q <= data_valid_d;
         data_byte_q <= data_byte_d;
         msg_end_q <= msg_end_d;
         err_valid_q <= err_valid_d;
         err_code_q <= err_code_d;
      end
   end

   // Checks on the parser behaviour
   property p_term_root;
      @(posedge clock) disable iff (rst)
      in_valid && is_term |=> level_q == scpi_parser_pkg::N_ROOT;
   endproperty
   a_term_root: assert property (p_term_root) else $error("level not root after end");

   property p_lead_colon;
      @(posedge clock) disable iff (rst)
      in_valid && state_q == scpi_parser_pkg::S_UNIT && in_byte == scpi_parser_pkg::CH_COLON
      |=> level_q == scpi_parser_pkg::N_ROOT && state_q == scpi_parser_pkg::S_KEY;
   endproperty
   a_lead_colon: assert property (p_lead_colon) else $error("root colon ignored");

   property p_descend;
      @(posedge clock) disable iff (rst)
      in_valid && state_q == scpi_parser_pkg::S_KEY && hit &&
      hit_node != scpi_parser_pkg::N_SOUR && in_byte == scpi_parser_pkg::CH_COLON
      |=> kw_valid_q && level_q == kw_node_q;
   endproperty
   a_descend: assert property (p_descend) else $error("no descent on colon");

   property p_query;
      @(posedge clock) disable iff (rst)
      in_valid && state_q == scpi_parser_pkg::S_KEY && hit && in_byte == scpi_parser_pkg::CH_QUERY
      ##1 in_valid && in_byte == scpi_parser_pkg::CH_SEMI |=> unit_valid_q && unit_query_q;
   endproperty
   a_query: assert property (p_query) else $error("query not flagged");

   property p_miss;
      @(posedge clock) disable iff (rst)
      in_valid && state_q == scpi_parser_pkg::S_KEY && !is_letter && !hit
      |=> err_valid_q && err_code_q == scpi_parser_pkg::ERR_UNDEF && !unit_valid_q;
   endproperty
   a_miss: assert property (p_miss) else $error("bad keyword accepted");

   property p_discard;
      @(posedge clock) disable iff (rst)
      in_valid && state_q == scpi_parser_pkg::S_DISCARD && !is_term
      |=> state_q == scpi_parser_pkg::S_DISCARD && !kw_valid_q && !unit_valid_q &&
          !data_valid_q && !err_valid_q && !msg_end_q;
   endproperty
   a_discard: assert property (p_discard) else $error("unit after error");

   property p_crlf;
      @(posedge clock) disable iff (rst)
      in_valid && in_byte == scpi_parser_pkg::CH_CR ##1 in_valid && in_byte == scpi_parser_pkg::CH_LF
      |=> !msg_end_q && !err_valid_q;
   endproperty
   a_crlf: assert property (p_crlf) else $error("second terminator acted");

   property p_data;
      @(posedge clock) disable iff (rst)
      in_valid && state_q == scpi_parser_pkg::S_DATA && !is_term && in_byte != scpi_parser_pkg::CH_SEMI
      |=> data_valid_q && data_byte_q == $past(in_byte);
   endproperty
   a_data: assert property (p_data) else $error("parameter byte lost");

   property p_sibling;
      @(posedge clock) disable iff (rst)
      in_valid && state_q == scpi_parser_pkg::S_KEY && hit && in_byte == scpi_parser_pkg::CH_SEMI
      |=> unit_valid_q && level_q == $past(level_q);
   endproperty
   a_sibling: assert property (p_sibling) else $error("level not kept");

   property p_common;
      @(posedge clock) disable iff (rst)
      in_valid && state_q == scpi_parser_pkg::S_UNIT && in_byte == scpi_parser_pkg::CH_STAR
      |=> state_q == scpi_parser_pkg::S_COMMON && !kw_valid_q;
   endproperty
   a_common: assert property (p_common) else $error("common not taken");

   // Main scenarios
   c_query_unit: cover property (@(posedge clock) unit_valid_q && unit_query_q);
   c_error: cover property (@(posedge clock) err_valid_q);
   c_common: cover property (@(posedge clock) unit_valid_q && unit_common_q);
   c_crlf: cover property (@(posedge clock) last_cr_q && in_valid && skip);

endmodule // scpi_message_parser

// ---- test/host_model.sv ----
// Host controller model that sends program messages as a byte stream
module host_model (
   // Clock
   input wire logic clock,
   // Byte stream towards the parser
   output logic in_valid,
   output logic [7:0] in_byte
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle start, line quiet
   initial begin
      in_valid = 1'b0;
      in_byte = 8'h00;
   end

   // Sends one whole message, terminator included by caller, gap idle cycles between bytes
   task automatic send(input string s, input int gap);
      for (int i = 0; i < s.len(); i++) begin
         @(negedge clock);
         in_valid = 1'b1;
         in_byte = s[i];
         for (int g = 0; g < gap; g++) begin
            @(negedge clock);
            in_valid = 1'b0;
            in_byte = ~in_byte;
         end
      end
      @(negedge clock);
      // Released line shows the inverse of what it held; after an odd gap that is the last byte again
      in_valid = 1'b0;
      in_byte = ~in_byte;
   endtask
endmodule // host_model

// ---- test/scpi_message_parser_bench.sv ----
// Self-checking bench for the command message parser
module scpi_message_parser_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst, in_valid, kw_valid_q, unit_valid_q, unit_query_q, unit_common_q;
   logic data_valid_q, msg_end_q, err_valid_q;
   logic [7:0] in_byte, data_byte_q, err_code_q;
   logic [4:0] kw_node_q, unit_node_q, level_q;
   int failures, cmp_count, seed, dv;
   logic [15:0] notes[$]; // Expected results, oldest first
   logic skip_data; // Common units carry no keyword node
   logic [11:0] roots[6] = '{12'h001, 12'h002, 12'h003, 12'h005, 12'h006, 12'h009};
   string rname[6] = '{"INIT?\n", "meas?\n", "OUTPUT?\n", "Stat?\n", "SYSTEM?\n", "func?\n"};

   // Clock of 100 ns period
   always #50 clock = ~clock;

   // Host side and design
   host_model hm (.clock(clock), .in_valid(in_valid), .in_byte(in_byte));
   scpi_message_parser uut (.clock(clock), .rst(rst), .in_valid(in_valid), .in_byte(in_byte),
      .kw_valid_q(kw_valid_q), .kw_node_q(kw_node_q), .unit_valid_q(unit_valid_q),
      .unit_node_q(unit_node_q), .unit_query_q(unit_query_q), .unit_common_q(unit_common_q),
      .data_valid_q(data_valid_q), .data_byte_q(data_byte_q), .msg_end_q(msg_end_q),
      .err_valid_q(err_valid_q), .err_code_q(err_code_q), .level_q(level_q));

   // Compares one result against the oldest note
   task automatic cmp_note(input logic [15:0] got);
      logic [15:0] exp;
      exp = 16'hffff;
      if (notes.size() > 0) exp = notes.pop_front();
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   // Compares the tree level
   task automatic cmp_level(input logic [4:0] exp);
      cmp_count++;
      if (level_q !== exp) begin
         failures++;
         $display("Error at %0t: level expected %h got %h", $time, exp, level_q);
      end
   endtask

   // Notes one expected result: kind 1 keyword, 2 unit, 3 data, 4 error, 5 end
   task automatic e(input logic [3:0] k, input logic [11:0] v);
      notes.push_back({k, v});
   endtask

   // Prints counts and verdict, then stops
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Sends a message and waits, bounded, for all noted results
   task automatic run(input string s, input int gap);
      int n;
      hm.send(s, gap);
      n = 0;
      while (notes.size() > 0 && n < 20) begin
         @(negedge clock);
         n++;
      end
      repeat (2) @(negedge clock);
      if (notes.size() > 0) begin
         failures++;
         $display("Error at %0t: results pending expected %h got %h", $time, 0, notes.size());
         report_and_stop();
      end
      cmp_level(scpi_parser_pkg::N_ROOT);
      $display("Test done: %s", s);
   endtask

   // Watches outputs where settled, in fixed order within a cycle
   always @(negedge clock) begin
      if (!rst) begin
         if (kw_valid_q === 1'b1) cmp_note({4'h1, 7'h00, kw_node_q});
         if (data_valid_q === 1'b1) cmp_note({8'h30, data_byte_q});
         if (unit_valid_q === 1'b1) begin
            cmp_note({6'h08, unit_query_q, unit_common_q, 3'h0,
                      skip_data ? 5'h00 : unit_node_q});
         end
         if (err_valid_q === 1'b1) cmp_note({8'h40, err_code_q});
         if (msg_end_q === 1'b1) cmp_note(16'h5000);
      end
   end

   // Main sequence
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      seed = 35702;
      skip_data = 1'b0;
      failures = 0;
      cmp_count = 0;
      repeat (6) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      e(1, 'h07); e(2, 'h207); e(1, 'h08);
      e(3, 'h35); e(2, 'h008); e(5, 0);
      run("volt?;curr 5\n", 0);
      e(1, 'h07); e(1, 'h10); e(1, 'h11); e(2, 'h011); e(5, 0);
      run("vOlTage:lev:IMMEDIATE\015\n", 1);
      e(1, 'h07); e(1, 'h10); e(3, 'h36); e(2, 'h010); e(1, 'h08); e(1, 'h17); e(3, 'h31);
      e(2, 'h017); e(5, 0);
      run("VOLT:LEV 6;:CURR:LEV 1\015", 0);
      e(1, 'h02); e(1, 'h15); e(2, 'h215); e(1, 'h16); e(2, 'h216); e(5, 0);
      run("meas:volt?;curr?\n", 0);
      e(1, 'h02); e(1, 'h15); e(2, 'h215); e(4, 'h01); e(5, 0);
      run("MEAS:VOLT?;STAT\n", 0);
      e(1, 'h07); e(4, 'h01); e(5, 0);
      run("VOLT:LEVE\n", 0);
      e(1, 'h05); e(4, 'h01); e(5, 0);
      run("STAT:OPERA:COND?;VOLT\n", 0);
      e(1, 'h07); e(4, 'h02); e(5, 0);
      run("VOLT#;CURR\n", 0);
      e(4, 'h03); e(5, 0);
      run("QUESTIONABLEX\n", 0);
      e(1, 'h03); e(1, 'h13); e(3, 'h31); e(2, 'h013); e(5, 0);
      run("OUTP:STAT 1\015\n", 0);
      e(1, 'h06); e(1, 'h14); e(2, 'h214); e(5, 0);
      run("SYST:ERR?\n", 2);
      e(1, 'h04); e(1, 'h07); e(3, 'h31); e(2, 'h007); e(5, 0);
      run("SOUR:VOLT 1\n", 0);
      skip_data = 1'b1;
      e(3, 'h52); e(3, 'h53); e(3, 'h54); e(2, 'h100);
      e(3, 'h4f); e(3, 'h50); e(3, 'h43); e(3, 'h3f); e(2, 'h300); e(5, 0);
      run("*RST;*OPC?\n", 0);
      skip_data = 1'b0;
      for (int i = 0; i < 6; i++) begin
         e(1, roots[i]); e(2, 12'h200 | roots[i]); e(5, 0);
         run(rname[i], 0);
      end
      repeat (4) begin
         dv = $unsigned($random(seed)) % 10;
         e(1, 'h08); e(3, 12'h030 + dv[11:0]); e(2, 'h008); e(5, 0);
         run($sformatf("CURR %0d\n", dv), dv % 3);
      end
      report_and_stop();
   end
endmodule // scpi_message_parser_bench
